// >>> pnci_pkg.sv
package pnci_pkg;

	// Array geometry: four blocks of sixteen 16-bit words
	localparam int DATA_W    = 16;
	localparam int ADDR_W    = 6;
	localparam int BLK_W     = 2;
	localparam int WORD_W    = ADDR_W - BLK_W;
	localparam int NUM_BLK   = 4;
	localparam int NUM_WORDS = 64;
	localparam int WPB       = NUM_WORDS / NUM_BLK;

	localparam logic [DATA_W-1:0]  ERASED_WORD  = 16'hFFFF;
	localparam logic [DATA_W-1:0]  BLOCKED_WORD = 16'h0000;
	localparam logic [NUM_BLK-1:0] LOCK_RESET   = 4'hF;

	// Command bytes on dq[7:0]
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ID     = 8'h90;
	localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
	localparam logic [7:0] CMD_PROGRAM     = 8'h40;
	localparam logic [7:0] CMD_ERASE       = 8'h20;
	localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
	localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
	localparam logic [7:0] CMD_LOCK        = 8'h01;
	localparam logic [7:0] CMD_CONFIG      = 8'h03;
	localparam logic [7:0] CMD_PASSWORD    = 8'h2F;

	// Status byte bit positions
	localparam int ST_READY    = 7;
	localparam int ST_ERS_SUSP = 6;
	localparam int ST_ERS_ERR  = 5;
	localparam int ST_PRG_ERR  = 4;
	localparam int ST_SUP_ERR  = 3;
	localparam int ST_PRG_SUSP = 2;
	localparam int ST_LOCK_ERR = 1;

	// Read configuration carried on the address pins
	localparam int CFG_ASYNC_BIT = 5;
	localparam int CFG_LAT_LSB   = 2;
	localparam int LAT_W         = 3;

	// Identifier words within a block while in identifier read
	localparam logic [WORD_W-1:0] ID_OFS_UID_LO = 4'h0;
	localparam logic [WORD_W-1:0] ID_OFS_UID_HI = 4'h1;

	// Self-timed algorithm durations
	localparam int CLK_PERIOD_NS = 5;
	localparam int PROG_TIME_NS  = 2000;
	localparam int ERASE_TIME_NS = 20000;
	localparam int PROG_CYCLES   =
		(PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES  =
		(ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ALGO_CNT_W    = 16;

	// AXI4-Lite register map
	localparam logic [31:0] REG_STATUS = 32'h0000_0000;
	localparam logic [31:0] REG_UID    = 32'h0000_0004;
	localparam logic [31:0] REG_PWD    = 32'h0000_0008;
	localparam logic [31:0] REG_PROT   = 32'h0000_000C;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [15:0] PWD_RESET   = 16'h0000;
	localparam logic [7:0]  PROT_RESET  = 8'h00;
	localparam int          PROT_RD_LSB = 4;

	typedef enum logic [1:0] {RD_ARRAY, RD_STATUS, RD_ID} pnci_rdsel_type;
	typedef enum logic [2:0] {
		CS_IDLE, CS_PROGRAM, CS_ERASE, CS_LOCK, CS_PASSWORD
	} pnci_cmd_type;

endpackage : pnci_pkg

// >>> pnci_sync.sv
`timescale 1ns/1ps
module pnci_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             clk,
	input  wire logic             rstN,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	// Only the second stage is visible outside
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta_q <= INIT;
			dout   <= INIT;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : pnci_sync

// >>> pnci_algo.sv
`timescale 1ns/1ps
module pnci_algo import pnci_pkg::*; #(
	parameter int unsigned CYCLES = 1
) (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic start,
	input  wire logic suspend,
	input  wire logic resume,
	output logic      busy,
	output logic      paused,
	output logic      done
);
	localparam logic [ALGO_CNT_W-1:0] LAST = ALGO_CNT_W'(CYCLES - 1);
	logic [ALGO_CNT_W-1:0] cnt_q;

	// Paused time does not count; the run resumes where it stopped
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			busy   <= 1'b0;
			paused <= 1'b0;
			done   <= 1'b0;
			cnt_q  <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy   <= 1'b1;
				paused <= 1'b0;
				cnt_q  <= '0;
			end else if (busy && !paused) begin
				if (suspend) begin
					paused <= 1'b1;
				end else if (cnt_q == LAST) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end else if (busy && paused && resume) begin
				paused <= 1'b0;
			end
		end
	end
endmodule : pnci_algo

// >>> pnci_flash_top.sv
// What this block does
// - After reset the pins read in asynchronous mode.
// - A configuration write selects synchronous burst reads.
// - Burst words advance on edges of the host-supplied link clock.
// - Wait output is high while burst data is not yet valid.
// - Data, commands and reads all use the 16-bit data pins.
// - Accepted program or erase runs self-timed to completion.
// - Status byte shows completion and errors of program and erase.
// - An erase clears exactly the one addressed block.
// - Erase can be suspended to read or program another block.
// - Program can be suspended to read other locations.
// - Programming writes exactly one 16-bit word.
// - Program and erase are refused while supply is below lockout.
// - Each block has a lock bit that acts immediately.
// - Password guards write and read access of chosen blocks.
// - A one-time programmed unique identifier can be read.
// - Sync mode captures address on strobe rise or first clock edge.
// - Async mode latches address on strobe rise, flows while low.
`timescale 1ns/1ps
module pnci_flash_top import pnci_pkg::*; #(
	// Arbitrary value standing in for the factory identifier
	parameter logic [31:0] UNIQUE_ID = 32'hA5C3_0F1E
) (
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] flashAddr,
	input  wire logic [DATA_W-1:0] dqIn,
	input  wire logic              ceN,
	input  wire logic              oeN,
	input  wire logic              weN,
	input  wire logic              addressValidN,
	input  wire logic              linkClk,
	input  wire logic              supplyAboveLockout,
	output logic      [DATA_W-1:0] dqOut,
	output logic                   dqOe,
	output logic                   waitOut,
	input  wire logic [31:0]       awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [31:0]       araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready
);
	logic                   rstN;
	logic [ADDR_W-1:0]      addrS;
	logic [DATA_W-1:0]      dqS;
	logic                   ceNS, oeNS, weNS, advNS, linkClkS, vppS;
	logic                   weNLast_q, advNLast_q, clkLast_q;
	logic                   wrEv, advRise, advFall, clkRise, capt;
	logic [7:0]             cmd, stat;
	logic [BLK_W-1:0]       wrBlk, eraseBlk_q;
	logic                   cfgAsyncBit;
	pnci_cmd_type           cmdState_q;
	pnci_rdsel_type         readSel_q;
	logic [NUM_BLK-1:0]     lock_q;
	logic                   syncMode_q, pwdOpen_q;
	logic [LAT_W-1:0]       latency_q, latCnt_q;
	logic                   stPrgErr_q, stErsErr_q, stSupErr_q, stLockErr_q;
	logic [ADDR_W-1:0]      progAddr_q, addrLat_q, burstAddr_q;
	logic [DATA_W-1:0]      progData_q;
	logic [DATA_W-1:0]      mem [0:NUM_WORDS-1];
	logic                   progStart, eraseStart, progSusp, eraseSusp;
	logic                   progRes, eraseRes, errPrg, errErs;
	logic                   errLock, errSup, clrStat;
	logic                   progBusy, progPaused, progDone;
	logic                   eraseBusy, erasePaused, eraseDone;
	logic                   burstOn_q, capDone_q;
	logic [15:0]            pwd_q;
	logic [7:0]             prot_q;
	logic [31:0]            awAddr_q, wData_q;
	logic [3:0]             wStrb_q;
	logic                   awHeld_q, wHeld_q, regWrite, pwdWrite;

	pnci_sync #(.WIDTH(1), .INIT(1'b0)) rstSync (
		.clk(core_clk), .rstN(rst_b), .din(1'b1), .dout(rstN));

	// Every pin passes two flops; data is stable around strobe edges
	pnci_sync #(.WIDTH(ADDR_W + DATA_W + 6),
		.INIT({{(ADDR_W + DATA_W){1'b0}}, 6'h3C})) pinSync (
		.clk(core_clk), .rstN(rstN),
		.din({flashAddr, dqIn, ceN, oeN, weN, addressValidN, linkClk,
			supplyAboveLockout}),
		.dout({addrS, dqS, ceNS, oeNS, weNS, advNS, linkClkS, vppS}));

	pnci_algo #(.CYCLES(PROG_CYCLES)) progEng (
		.clk(core_clk), .rstN(rstN), .start(progStart),
		.suspend(progSusp), .resume(progRes), .busy(progBusy),
		.paused(progPaused), .done(progDone));

	pnci_algo #(.CYCLES(ERASE_CYCLES)) eraseEng (
		.clk(core_clk), .rstN(rstN), .start(eraseStart),
		.suspend(eraseSusp), .resume(eraseRes), .busy(eraseBusy),
		.paused(erasePaused), .done(eraseDone));

	function automatic logic [BLK_W-1:0] blkOf(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1 -: BLK_W];
	endfunction : blkOf

	function automatic logic writeBlocked(input logic [BLK_W-1:0] b);
		return lock_q[b] || (prot_q[b] && !pwdOpen_q);
	endfunction : writeBlocked

	function automatic logic readBlocked(input logic [BLK_W-1:0] b);
		return prot_q[PROT_RD_LSB + int'(b)] && !pwdOpen_q;
	endfunction : readBlocked

	function automatic logic [DATA_W-1:0] readWord(
		input logic [ADDR_W-1:0] a);
		logic [BLK_W-1:0] b;
		b = blkOf(a);
		case (readSel_q)
			RD_STATUS: readWord = {8'h00, stat};
			RD_ID: begin
				if (a[WORD_W-1:0] == ID_OFS_UID_LO)
					readWord = UNIQUE_ID[15:0];
				else if (a[WORD_W-1:0] == ID_OFS_UID_HI)
					readWord = UNIQUE_ID[31:16];
				else
					readWord = {14'h0000, readBlocked(b), lock_q[b]};
			end
			default: readWord = readBlocked(b) ? BLOCKED_WORD : mem[a];
		endcase
	endfunction : readWord

	assign cmd         = dqS[7:0];
	assign wrBlk       = blkOf(addrS);
	assign cfgAsyncBit = addrS[CFG_ASYNC_BIT];
	assign wrEv    = weNS && !weNLast_q && !ceNS;
	assign advRise = advNS && !advNLast_q;
	assign advFall = !advNS && advNLast_q;
	assign clkRise = linkClkS && !clkLast_q;
	assign capt    = syncMode_q && readSel_q == RD_ARRAY && !ceNS &&
		!capDone_q && (advRise || (clkRise && !advNS));

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			weNLast_q  <= 1'b1;
			advNLast_q <= 1'b1;
			clkLast_q  <= 1'b0;
		end else begin
			weNLast_q  <= weNS;
			advNLast_q <= advNS;
			clkLast_q  <= linkClkS;
		end
	end

	// Decode of suspend, resume, clear status and the second program and erase cycles
	always_comb begin
		progStart = 1'b0; eraseStart = 1'b0;
		progSusp  = 1'b0; eraseSusp  = 1'b0;
		progRes   = 1'b0; eraseRes   = 1'b0;
		errPrg    = 1'b0; errErs     = 1'b0;
		errLock   = 1'b0; errSup     = 1'b0;
		clrStat   = wrEv && cmdState_q == CS_IDLE && cmd == CMD_CLEAR_STAT;
		if (wrEv) begin
			case (cmdState_q)
				CS_IDLE: begin
					if (cmd == CMD_SUSPEND) begin
						if (progBusy && !progPaused)
							progSusp = 1'b1;
						else if (eraseBusy && !erasePaused)
							eraseSusp = 1'b1;
					end
					if (cmd == CMD_CONFIRM) begin
						if (progPaused)
							progRes = 1'b1;
						else if (erasePaused)
							eraseRes = 1'b1;
					end
				end
				CS_PROGRAM: begin
					errPrg = 1'b1;
					if (!vppS)
						errSup = 1'b1;
					else if (writeBlocked(wrBlk))
						errLock = 1'b1;
					else if (progBusy || (eraseBusy &&
						(!erasePaused || wrBlk == eraseBlk_q)))
						errPrg = 1'b1;
					else begin
						errPrg    = 1'b0;
						progStart = 1'b1;
					end
				end
				CS_ERASE: begin
					errErs = 1'b1;
					if (cmd != CMD_CONFIRM)
						errPrg = 1'b1;
					else if (!vppS)
						errSup = 1'b1;
					else if (writeBlocked(wrBlk))
						errLock = 1'b1;
					else if (!(eraseBusy || progBusy)) begin
						errErs     = 1'b0;
						eraseStart = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// Command state, read select, locks, configuration, password
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			cmdState_q <= CS_IDLE;
			readSel_q  <= RD_ARRAY;
			lock_q     <= LOCK_RESET;
			syncMode_q <= 1'b0;
			latency_q  <= '0;
			pwdOpen_q  <= 1'b0;
		end else begin
			if (pwdWrite)
				pwdOpen_q <= 1'b0;
			if (wrEv) begin
				cmdState_q <= CS_IDLE;
				case (cmdState_q)
					CS_IDLE: begin
						case (cmd)
							CMD_READ_ARRAY:  readSel_q <= RD_ARRAY;
							CMD_READ_ID:     readSel_q <= RD_ID;
							CMD_PROGRAM:     cmdState_q <= CS_PROGRAM;
							CMD_ERASE:       cmdState_q <= CS_ERASE;
							CMD_LOCK_SETUP:  cmdState_q <= CS_LOCK;
							CMD_PASSWORD:    cmdState_q <= CS_PASSWORD;
							CMD_READ_STATUS,
							CMD_SUSPEND,
							CMD_CONFIRM:     readSel_q <= RD_STATUS;
							default: ;
						endcase
					end
					CS_LOCK: begin
						if (cmd == CMD_LOCK)
							lock_q[wrBlk] <= 1'b1;
						else if (cmd == CMD_CONFIRM)
							lock_q[wrBlk] <= 1'b0;
						else if (cmd == CMD_CONFIG) begin
							syncMode_q <= !cfgAsyncBit;
							latency_q  <= addrS[CFG_LAT_LSB +: LAT_W];
						end
					end
					CS_PASSWORD:
						if (dqS == pwd_q && !pwdWrite)
							pwdOpen_q <= 1'b1;
					default:
						readSel_q <= RD_STATUS;
				endcase
			end
		end
	end

	// Hardware sets win over a simultaneous clear
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			stPrgErr_q  <= 1'b0;
			stErsErr_q  <= 1'b0;
			stSupErr_q  <= 1'b0;
			stLockErr_q <= 1'b0;
		end else begin
			stPrgErr_q  <= (stPrgErr_q && !clrStat) || errPrg ||
				(progDone && !vppS);
			stErsErr_q  <= (stErsErr_q && !clrStat) || errErs ||
				(eraseDone && !vppS);
			stSupErr_q  <= (stSupErr_q && !clrStat) || errSup ||
				((progDone || eraseDone) && !vppS);
			stLockErr_q <= (stLockErr_q && !clrStat) || errLock;
		end
	end

	always_comb begin
		stat = 8'h00;
		stat[ST_READY]    = !((progBusy && !progPaused) ||
			(eraseBusy && !erasePaused));
		stat[ST_ERS_SUSP] = erasePaused;
		stat[ST_ERS_ERR]  = stErsErr_q;
		stat[ST_PRG_ERR]  = stPrgErr_q;
		stat[ST_SUP_ERR]  = stSupErr_q;
		stat[ST_PRG_SUSP] = progPaused;
		stat[ST_LOCK_ERR] = stLockErr_q;
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			progAddr_q <= '0;
			progData_q <= '0;
			eraseBlk_q <= '0;
		end else begin
			if (progStart) begin
				progAddr_q <= addrS;
				progData_q <= dqS;
			end
			if (eraseStart)
				eraseBlk_q <= wrBlk;
		end
	end

	// Supply below lockout in the done cycle discards the result
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < NUM_WORDS; i++)
				mem[i] <= ERASED_WORD;
		end else begin
			if (progDone && vppS)
				mem[progAddr_q] <= mem[progAddr_q] & progData_q;
			if (eraseDone && vppS)
				for (int i = 0; i < WPB; i++)
					mem[{eraseBlk_q, WORD_W'(i)}] <= ERASED_WORD;
		end
	end

	// Pin read path: address latch, burst engine and data drive
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			addrLat_q   <= '0;
			burstOn_q   <= 1'b0;
			capDone_q   <= 1'b0;
			burstAddr_q <= '0;
			latCnt_q    <= '0;
			waitOut     <= 1'b0;
			dqOut       <= '0;
			dqOe        <= 1'b0;
		end else begin
			if (!advNS)
				addrLat_q <= addrS;
			dqOe <= !ceNS && !oeNS && weNS;
			if (ceNS || advFall) begin
				burstOn_q <= 1'b0;
				capDone_q <= 1'b0;
				waitOut   <= 1'b0;
			end else if (capt) begin
				burstOn_q   <= 1'b1;
				capDone_q   <= 1'b1;
				burstAddr_q <= advRise ? addrLat_q : addrS;
				latCnt_q    <= latency_q;
				waitOut     <= 1'b1;
			end else if (burstOn_q && clkRise) begin
				if (latCnt_q != '0)
					latCnt_q <= latCnt_q - 1'b1;
				else begin
					dqOut       <= readWord(burstAddr_q);
					burstAddr_q <= burstAddr_q + 1'b1;
					waitOut     <= 1'b0;
				end
			end
			if (!(syncMode_q && readSel_q == RD_ARRAY))
				dqOut <= readWord(addrLat_q);
		end
	end

	// AXI4-Lite write channel; address and data taken in either order
	assign regWrite = awHeld_q && wHeld_q && !bvalid;
	assign pwdWrite = regWrite && awAddr_q == REG_PWD;

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			bvalid   <= 1'b0;
			bresp    <= RESP_OKAY;
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= '0;
			wData_q  <= '0;
			wStrb_q  <= '0;
		end else begin
			if (awvalid && awready) begin
				awAddr_q <= awaddr;
				awHeld_q <= 1'b1;
				awready  <= 1'b0;
			end
			if (wvalid && wready) begin
				wData_q <= wdata;
				wStrb_q <= wstrb;
				wHeld_q <= 1'b1;
				wready  <= 1'b0;
			end
			if (regWrite) begin
				bvalid   <= 1'b1;
				awHeld_q <= 1'b0;
				wHeld_q  <= 1'b0;
				bresp    <= (awAddr_q == REG_STATUS || awAddr_q == REG_UID ||
					awAddr_q == REG_PWD || awAddr_q == REG_PROT) ?
					RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			pwd_q  <= PWD_RESET;
			prot_q <= PROT_RESET;
		end else if (regWrite) begin
			if (awAddr_q == REG_PWD && wStrb_q[0])
				pwd_q[7:0] <= wData_q[7:0];
			if (awAddr_q == REG_PWD && wStrb_q[1])
				pwd_q[15:8] <= wData_q[15:8];
			if (awAddr_q == REG_PROT && wStrb_q[0])
				prot_q <= wData_q[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rresp   <= RESP_OKAY;
				case (araddr)
					REG_STATUS: rdata <= {16'h0000, lock_q, 2'b00, pwdOpen_q,
						syncMode_q, stat};
					REG_UID:    rdata <= UNIQUE_ID;
					REG_PWD:    rdata <= {16'h0000, pwd_q};
					REG_PROT:   rdata <= {24'h000000, prot_q};
					default: begin
						rdata <= '0;
						rresp <= RESP_SLVERR;
					end
				endcase
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// Running time of the program engine; suspended cycles do not count
	localparam logic [ALGO_CNT_W-1:0] PROG_RUN = ALGO_CNT_W'(PROG_CYCLES);
	logic [ALGO_CNT_W-1:0] progRun_q;

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN)
			progRun_q <= '0;
		else if (progStart)
			progRun_q <= '0;
		else if (progBusy && !progPaused && !progSusp)
			progRun_q <= progRun_q + 1'b1;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstN);

	a_async_default: assert property ($rose(rstN) |-> !syncMode_q)
		else $error("read mode not asynchronous after reset");
	a_config_burst: assert property (wrEv && cmdState_q == CS_LOCK &&
		cmd == CMD_CONFIG |=> syncMode_q == !$past(cfgAsyncBit))
		else $error("configuration write did not set read mode");
	a_burst_advance: assert property (burstOn_q && clkRise &&
		latCnt_q == '0 && !ceNS && !advFall && !capt
		|=> burstAddr_q == $past(burstAddr_q) + 1'b1)
		else $error("burst address did not advance on clock edge");
	a_wait_latency: assert property (burstOn_q && latCnt_q != '0
		|-> waitOut)
		else $error("wait low during latency");
	a_prog_selftimed: assert property (progStart |=>
		!stat[ST_READY] && progBusy)
		else $error("program did not run self-timed");
	a_prog_duration: assert property (progDone |->
		progRun_q == PROG_RUN)
		else $error("program run length wrong");
	a_supply_refuse: assert property (!vppS |->
		!progStart && !eraseStart)
		else $error("operation started below lockout");
	a_lock_immediate: assert property (wrEv && cmdState_q == CS_LOCK &&
		cmd == CMD_LOCK |=> lock_q[$past(wrBlk)])
		else $error("lock bit not set at once");
	a_locked_refuse: assert property (wrEv && cmdState_q == CS_PROGRAM &&
		vppS && lock_q[wrBlk] |-> !progStart ##1 stLockErr_q && stPrgErr_q)
		else $error("locked block program not refused");
	a_erase_suspend: assert property (eraseSusp |=>
		erasePaused && stat[ST_ERS_SUSP] && stat[ST_READY])
		else $error("erase suspend not taken");
	a_prog_suspend: assert property (progSusp |=>
		progPaused && stat[ST_PRG_SUSP])
		else $error("program suspend not taken");
	a_addr_hold: assert property (advNS |=> $stable(addrLat_q))
		else $error("latched address moved while strobe high");
	a_sync_capture: assert property (capt && advRise
		|=> burstOn_q && burstAddr_q == $past(addrLat_q))
		else $error("burst address not captured at strobe rise");

	c_burst_data: cover property (burstOn_q && clkRise && latCnt_q == '0);
	c_erase_suspend: cover property (eraseSusp ##[1:50] progStart);
	c_prog_done: cover property (progDone && vppS);
endmodule : pnci_flash_top

// >>> pnci_host_model.sv
`timescale 1ns/1ps
module pnci_host_model import pnci_pkg::*; (
	input  wire logic              clk,
	input  wire logic [DATA_W-1:0] dqOut,
	input  wire logic              waitOut,
	output logic      [ADDR_W-1:0] flashAddr,
	output logic      [DATA_W-1:0] dqIn,
	output logic                   ceN,
	output logic                   oeN,
	output logic                   weN,
	output logic                   addressValidN,
	output logic                   linkClk
);
	// Strobe held low so addresses flow; link clock still outside bursts
	initial begin
		flashAddr = '0;
		dqIn = '0;
		ceN = 1'b1;
		oeN = 1'b1;
		weN = 1'b1;
		addressValidN = 1'b0;
		linkClk = 1'b0;
	end
	// Levels held 4 clocks so the two-flop pin sampling sees each one
	task cmd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		flashAddr <= a;
		dqIn <= d;
		ceN <= 1'b0;
		weN <= 1'b0;
		repeat (4) @(posedge clk);
		weN <= 1'b1;
		repeat (4) @(posedge clk);
		ceN <= 1'b1;
		dqIn <= ~d;
	endtask : cmd
	task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		flashAddr <= a;
		ceN <= 1'b0;
		oeN <= 1'b0;
		repeat (10) @(posedge clk);
		d = dqOut;
		oeN <= 1'b1;
		ceN <= 1'b1;
	endtask : rd
	// Latency of one: capture on rise 1, count on rise 2, data on rise 3
	task burst(input logic [ADDR_W-1:0] a, output logic wt,
		output logic [DATA_W-1:0] d0, output logic [DATA_W-1:0] d1);
		@(posedge clk);
		flashAddr <= a;
		ceN <= 1'b0;
		oeN <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			#24 linkClk = 1'b1;
			#24 linkClk = 1'b0;
			if (i == 0)
				wt = waitOut;
			if (i == 2)
				d0 = dqOut;
		end
		d1 = dqOut;
		@(posedge clk);
		ceN <= 1'b1;
		oeN <= 1'b1;
	endtask : burst
endmodule : pnci_host_model

// >>> pnci_flash_top_tb_top.sv
`timescale 1ns/1ps
module pnci_flash_top_tb_top import pnci_pkg::*;;
	// Arbitrary identifier value
	localparam logic [31:0] UID = 32'h1357_2468;
	logic core_clk = 1'b0, rst_b = 1'b0, supplyAboveLockout = 1'b1;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, dqOe, waitOut;
	logic [1:0] bresp, rresp;
	logic [ADDR_W-1:0] flashAddr;
	logic [DATA_W-1:0] dqIn, dqOut, rw, pd, rw2;
	logic ceN, oeN, weN, addressValidN, linkClk, wt;
	logic [33:0] expQ[$];
	logic [3:0] w;
	int error_cnt = 0, check_count = 0, seed = 32'h3986;
	always #2.5 core_clk = ~core_clk;
	pnci_flash_top #(.UNIQUE_ID(UID)) dut_u (.core_clk(core_clk),
		.rst_b(rst_b), .flashAddr(flashAddr), .dqIn(dqIn), .ceN(ceN),
		.oeN(oeN), .weN(weN), .addressValidN(addressValidN),
		.linkClk(linkClk), .supplyAboveLockout(supplyAboveLockout),
		.dqOut(dqOut), .dqOe(dqOe), .waitOut(waitOut), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));
	pnci_host_model hostU (.clk(core_clk), .dqOut(dqOut), .waitOut(waitOut),
		.flashAddr(flashAddr), .dqIn(dqIn), .ceN(ceN), .oeN(oeN),
		.weN(weN), .addressValidN(addressValidN), .linkClk(linkClk));
	task check(input logic [33:0] seen, input logic [33:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task summarize;
		$display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task axiRd(input logic [31:0] a, input logic [1:0] r,
		input logic [31:0] e);
		expQ.push_back({r, e});
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge core_clk);
		rready <= 1'b0;
	endtask : axiRd
	task axiWr(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic da, dw;
		expQ.push_back({r, 32'h0});
		da = 0;
		dw = 0;
		@(posedge core_clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		do begin
			@(posedge core_clk);
			if (awready) begin
				da = 1;
				awvalid <= 1'b0;
			end
			if (wready) begin
				dw = 1;
				wvalid <= 1'b0;
			end
		end while (!(da && dw));
		while (!bvalid) @(posedge core_clk);
		bready <= 1'b0;
	endtask : axiWr
	// Results only count at the handshake edge, never while they stand
	always @(posedge core_clk) begin
		if (rvalid && rready)
			check({rresp, rdata}, expQ.size() ? expQ.pop_front() : 'x);
		if (bvalid && bready)
			check({bresp, 32'h0}, expQ.size() ? expQ.pop_front() : 'x);
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge core_clk);
		axiRd(REG_STATUS, RESP_OKAY, 32'h0000_F080);
		axiRd(REG_UID, RESP_OKAY, UID);
		axiRd(32'h10, RESP_SLVERR, 32'h0);
		axiWr(32'h14, 32'h1, RESP_SLVERR);
		w = $random(seed);
		pd = $random(seed);
		hostU.cmd({2'h0, w}, {8'h0, CMD_PROGRAM});
		hostU.cmd({2'h0, w}, pd);
		axiRd(REG_STATUS, RESP_OKAY, 32'h0000_F092);
		hostU.cmd({2'h0, w}, {8'h0, CMD_READ_ARRAY});
		hostU.rd({2'h0, w}, rw);
		check({33'h0, dqOe}, 34'h1);
		check({18'h0, rw}, {18'h0, ERASED_WORD});
		hostU.cmd(6'h10, {8'h0, CMD_CLEAR_STAT});
		hostU.cmd(6'h10, {8'h0, CMD_LOCK_SETUP});
		hostU.cmd(6'h10, {8'h0, CMD_CONFIRM});
		axiRd(REG_STATUS, RESP_OKAY, 32'h0000_D080);
		hostU.cmd({2'h1, w}, {8'h0, CMD_PROGRAM});
		hostU.cmd({2'h1, w}, pd);
		axiRd(REG_STATUS, RESP_OKAY, 32'h0000_D000);
		repeat (450) @(posedge core_clk);
		axiRd(REG_STATUS, RESP_OKAY, 32'h0000_D080);
		hostU.cmd({2'h1, w}, {8'h0, CMD_READ_ARRAY});
		hostU.rd({2'h1, w}, rw);
		check({18'h0, rw}, {18'h0, pd});
		hostU.cmd(6'h04, {8'h0, CMD_LOCK_SETUP});
		hostU.cmd(6'h04, {8'h0, CMD_CONFIG});
		hostU.burst({2'h1, w}, wt, rw, rw2);
		check({33'h0, wt}, 34'h1);
		check({18'h0, rw}, {18'h0, pd});
		check({18'h0, rw2}, {18'h0, ERASED_WORD});
		check({33'h0, waitOut}, 34'h0);
		hostU.cmd(6'h20, {8'h0, CMD_LOCK_SETUP});
		hostU.cmd(6'h20, {8'h0, CMD_CONFIG});
		hostU.cmd(6'h10, {8'h0, CMD_ERASE});
		hostU.cmd(6'h10, {8'h0, CMD_CONFIRM});
		repeat (4100) @(posedge core_clk);
		hostU.cmd(6'h10, {8'h0, CMD_READ_ARRAY});
		hostU.rd({2'h1, w}, rw);
		check({18'h0, rw}, {18'h0, ERASED_WORD});
		axiWr(REG_PROT, 32'h20, RESP_OKAY);
		axiRd(REG_PROT, RESP_OKAY, 32'h20);
		hostU.rd({2'h1, w}, rw);
		check({18'h0, rw}, {18'h0, BLOCKED_WORD});
		supplyAboveLockout <= 1'b0;
		hostU.cmd({2'h1, w}, {8'h0, CMD_PROGRAM});
		hostU.cmd({2'h1, w}, pd);
		axiRd(REG_STATUS, RESP_OKAY, 32'h0000_D098);
		repeat (4) @(posedge core_clk);
		summarize();
	end
endmodule : pnci_flash_top_tb_top
